// [logic/cmv_pkg.sv]
// Summary of operation
// - Smallest mode reaches 64 kbytes; only low 16 address bits are used.
// - Middle mode keeps low 16 address bits and sign-extends bit 15 through bit 23; top byte zero.
// - Middle mode: program up to 16 Mbytes, data confined to 64 kbytes.
// - Advanced mode: linear 4 Gbyte data, program limited to 16 Mbytes.
// - Maximum mode: program and data use the full 4 Gbyte space.
// - Smallest mode vector table starts at zero, one 16-bit address per entry.
// - Middle/advanced vectors are 32-bit entries; top eight bits ignored, low 24 used.
// - Maximum mode vector table at zero; whole 32-bit entry is the target.
// - Memory-indirect branches read the location given by an 8-bit field, then branch.
// - Middle/advanced indirect operand top eight bits reserved, zero, treated as zero.
// - Smallest mode pushes and pops the program counter as 16 bits.
// - Middle/advanced modes push and pop the program counter as 32 bits.
// - Maximum mode stacks a 32-bit program counter and always the extended control.
// - Increment/decrement carries from the lower half reach the upper half.
// - A control bit picks 16- or 32-bit fetch; data accesses are unaffected.
// - Add/subtract and 8x8/16x16 multiply take one state; 32x32 multiply five.
// - Divide takes 10 states for 16/8 and 18 for 32/16 and 32/32.
// - Power-down is entered only by the sleep instruction.
// - General register seven is the implicit stack pointer for calls and exceptions.
// - The lowest program counter bit is forced to zero on every fetch.
// - Exception handling sets the interrupt mask bit of the condition codes.
package cmv_pkg;
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_SP           = 8'h08;
  localparam logic [7:0]  REG_PC           = 8'h0c;
  localparam logic [7:0]  REG_FLAGS        = 8'h10;
  localparam int          CTRL_FETCH_BIT   = 0;
  localparam int          STAT_MODE_LSB    = 0;
  localparam int          STAT_SLEEP_BIT   = 2;
  localparam int          STAT_BUSY_BIT    = 3;
  localparam int          STAT_MODE_OK_BIT = 4;
  localparam int          FLAGS_EXR_LSB    = 8;
  localparam int          CCR_I_BIT        = 7;
  localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
  localparam logic [31:0] SP_RST           = 32'h0000_0000;
  localparam logic [31:0] PC_RST           = 32'h0000_0000;
  localparam logic [7:0]  CCR_RST          = 8'h80;
  localparam logic [7:0]  EXR_RST          = 8'h00;
  localparam logic [4:0]  ST_ONE           = 5'h01;
  localparam logic [4:0]  ST_MUL32         = 5'h05;
  localparam logic [4:0]  ST_DIV16_8       = 5'h0a;
  localparam logic [4:0]  ST_DIV32         = 5'h12;
  localparam logic [31:0] PUSH_HALF        = 32'h0000_0002;
  localparam logic [31:0] PUSH_WORD        = 32'h0000_0004;
  localparam logic [31:0] FRAME_SHORT      = 32'h0000_0004;
  localparam logic [31:0] FRAME_MAX        = 32'h0000_0008;
  localparam logic [1:0]  AXI_OKAY         = 2'h0;
  localparam logic [1:0]  AXI_SLVERR       = 2'h2;

  typedef enum logic [1:0] {
    CMV_NORMAL,
    CMV_MIDDLE,
    CMV_ADVANCED,
    CMV_MAXIMUM
  } cmv_mode_t;

  typedef enum logic [3:0] {
    CMV_OP_EA,
    CMV_OP_FETCH,
    CMV_OP_EXC,
    CMV_OP_IND_JUMP,
    CMV_OP_IND_CALL,
    CMV_OP_CALL,
    CMV_OP_RET,
    CMV_OP_RTE,
    CMV_OP_STEP,
    CMV_OP_ARITH,
    CMV_OP_SLEEP
  } cmv_op_t;

  typedef enum logic [2:0] {
    CMV_ADD,
    CMV_SUB,
    CMV_MUL8,
    CMV_MUL16,
    CMV_MUL32,
    CMV_DIV16_8,
    CMV_DIV32_16,
    CMV_DIV32_32
  } cmv_kind_t;

  typedef enum logic {
    CMV_IDLE,
    CMV_BUSY
  } cmv_state_t;

  typedef struct packed {
    cmv_op_t     op;
    cmv_kind_t   kind;
    logic [31:0] a;
    logic [31:0] b;
  } cmv_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic [31:0] table_addr;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
    logic [31:0] mem_aux;
    logic        mem_wide;
    logic        mem_write;
  } cmv_rsp_t;
endpackage : cmv_pkg

// [logic/cmv_core.sv]
module cmv_core (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [1:0]              mode_strap,
  input  wire logic                    wake,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire cmv_pkg::cmv_req_t       req,
  output logic                         rsp_valid,
  output cmv_pkg::cmv_rsp_t            rsp,
  output logic                         fetch_width_select,
  output logic                         sleeping,
  output cmv_pkg::cmv_mode_t           mode,
  input  wire logic [cmv_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [cmv_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  // Data address per mode
  function automatic logic [31:0] ea_adjust(cmv_pkg::cmv_mode_t m, logic [31:0] a);
    unique case (m)
      cmv_pkg::CMV_NORMAL: ea_adjust = {16'h0000, a[15:0]};
      cmv_pkg::CMV_MIDDLE: ea_adjust = {8'h00, {8{a[15]}}, a[15:0]};
      default:             ea_adjust = a;
    endcase
  endfunction : ea_adjust

  // Program address, vector entry, indirect operand and stacked PC per mode
  function automatic logic [31:0] prog_adjust(cmv_pkg::cmv_mode_t m, logic [31:0] a);
    unique case (m)
      cmv_pkg::CMV_NORMAL:  prog_adjust = {16'h0000, a[15:0]};
      cmv_pkg::CMV_MAXIMUM: prog_adjust = a;
      default:              prog_adjust = {8'h00, a[23:0]};
    endcase
  endfunction : prog_adjust

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  function automatic logic [4:0] states_of(cmv_pkg::cmv_kind_t k);
    unique case (k)
      cmv_pkg::CMV_MUL32:    states_of = cmv_pkg::ST_MUL32;
      cmv_pkg::CMV_DIV16_8:  states_of = cmv_pkg::ST_DIV16_8;
      cmv_pkg::CMV_DIV32_16,
      cmv_pkg::CMV_DIV32_32: states_of = cmv_pkg::ST_DIV32;
      default:               states_of = cmv_pkg::ST_ONE;
    endcase
  endfunction : states_of

  function automatic logic [31:0] arith(cmv_pkg::cmv_kind_t k, logic [31:0] a, logic [31:0] b);
    logic [31:0] dv;
    dv = '0;
    unique case (k)
      cmv_pkg::CMV_ADD:      arith = a + b;
      cmv_pkg::CMV_SUB:      arith = a - b;
      cmv_pkg::CMV_MUL8:     arith = {16'h0000, 16'(a[7:0]) * 16'(b[7:0])};
      cmv_pkg::CMV_MUL16:    arith = 32'(a[15:0]) * 32'(b[15:0]);
      cmv_pkg::CMV_MUL32:    arith = a * b;
      cmv_pkg::CMV_DIV16_8:
      begin
        dv = {24'h000000, b[7:0]};
        arith = (dv == 32'h0) ? 32'h0 : {16'h0000, a[15:0] / dv[15:0]};
      end
      cmv_pkg::CMV_DIV32_16:
      begin
        dv = {16'h0000, b[15:0]};
        arith = (dv == 32'h0) ? 32'h0 : a / dv;
      end
      default:               arith = (b == 32'h0) ? 32'h0 : a / b;
    endcase
  endfunction : arith

  logic [1:0]          strap_s1_r;
  logic [1:0]          strap_s2_r;
  cmv_pkg::cmv_mode_t  mode_r;
  logic                mode_ok_r;
  logic [31:0]         ctrl_r;
  logic [31:0]         sp_r;
  logic [31:0]         pc_r;
  logic [7:0]          ccr_r;
  logic [7:0]          exr_r;
  logic                sleep_r;
  cmv_pkg::cmv_state_t state_r;
  logic [4:0]          cnt_r;
  logic                rsp_valid_r;
  cmv_pkg::cmv_rsp_t   rsp_r;
  logic                awhave_r;
  logic                whave_r;
  logic [cmv_pkg::ADDR_W-1:0] awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;

  // Strap synchroniser runs through reset so the level is settled at release
  always_ff @(posedge aclk)
  begin
    strap_s1_r <= mode_strap;
    strap_s2_r <= strap_s1_r;
  end

  // Mode is caught once after reset and frozen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r    <= cmv_pkg::CMV_ADVANCED;
      mode_ok_r <= 1'b0;
    end
    else if (!mode_ok_r)
    begin
      mode_r    <= cmv_pkg::cmv_mode_t'(strap_s2_r);
      mode_ok_r <= 1'b1;
    end
  end

  // AXI4-Lite write path
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = awhave_r && whave_r && !bvalid_r;
  wire wr_ctrl  = wr_go && (awaddr_r == cmv_pkg::REG_CTRL);
  wire wr_sp    = wr_go && (awaddr_r == cmv_pkg::REG_SP);
  wire wr_pc    = wr_go && (awaddr_r == cmv_pkg::REG_PC);
  wire wr_flags = wr_go && (awaddr_r == cmv_pkg::REG_FLAGS);
  wire wr_hit   = wr_ctrl || wr_sp || wr_pc || wr_flags ||
                  (awaddr_r == cmv_pkg::REG_STATUS);

  assign s_axi_awready = !awhave_r && !bvalid_r;
  assign s_axi_wready  = !whave_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awhave_r <= 1'b0;
      whave_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= cmv_pkg::AXI_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        awhave_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        whave_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        awhave_r <= 1'b0;
        whave_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? cmv_pkg::AXI_OKAY : cmv_pkg::AXI_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
      begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  wire [31:0] status_w = {27'h0, mode_ok_r, (state_r == cmv_pkg::CMV_BUSY), sleep_r, mode_r};
  wire [31:0] flags_w  = {16'h0000, exr_r, ccr_r};
  wire        rd_hit   = (s_axi_araddr == cmv_pkg::REG_CTRL) || (s_axi_araddr == cmv_pkg::REG_STATUS) ||
                         (s_axi_araddr == cmv_pkg::REG_SP) || (s_axi_araddr == cmv_pkg::REG_PC) ||
                         (s_axi_araddr == cmv_pkg::REG_FLAGS);
  wire [31:0] rd_data  = (s_axi_araddr == cmv_pkg::REG_CTRL)   ? ctrl_r   :
                         (s_axi_araddr == cmv_pkg::REG_STATUS) ? status_w :
                         (s_axi_araddr == cmv_pkg::REG_SP)     ? sp_r     :
                         (s_axi_araddr == cmv_pkg::REG_PC)     ? pc_r     :
                         (s_axi_araddr == cmv_pkg::REG_FLAGS)  ? flags_w  : 32'h0;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= cmv_pkg::AXI_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data;
      rresp_r  <= rd_hit ? cmv_pkg::AXI_OKAY : cmv_pkg::AXI_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // Operation port; a pending register write holds requests off for one cycle
  wire fetch_wide = ctrl_r[cmv_pkg::CTRL_FETCH_BIT];
  wire wide_mode  = (mode_r != cmv_pkg::CMV_NORMAL);
  wire max_mode   = (mode_r == cmv_pkg::CMV_MAXIMUM);
  wire [31:0] push_sz  = wide_mode ? cmv_pkg::PUSH_WORD : cmv_pkg::PUSH_HALF;
  wire [31:0] frame_sz = max_mode ? cmv_pkg::FRAME_MAX : cmv_pkg::FRAME_SHORT;
  wire [31:0] pc_img   = prog_adjust(mode_r, pc_r);

  assign req_ready = (state_r == cmv_pkg::CMV_IDLE) && mode_ok_r && !sleep_r && !wr_go;
  wire accept = req_valid && req_ready;
  wire [31:0] flags_mrg = merge({16'h0000, exr_r, ccr_r}, wdata_r, wstrb_r);
  wire [31:0] ctrl_mrg  = merge(ctrl_r, wdata_r, wstrb_r);

  cmv_pkg::cmv_rsp_t r_nxt;
  logic [31:0]       sp_nxt;
  logic [31:0]       pc_nxt;
  logic [7:0]        ccr_nxt;
  logic [7:0]        exr_nxt;
  logic              sleep_nxt;
  logic [4:0]        lat_nxt;

  always_comb
  begin
    r_nxt     = '0;
    sp_nxt    = sp_r;
    pc_nxt    = pc_r;
    ccr_nxt   = ccr_r;
    exr_nxt   = exr_r;
    sleep_nxt = 1'b0;
    lat_nxt   = cmv_pkg::ST_ONE;
    unique case (req.op)
      cmv_pkg::CMV_OP_EA:
      begin
        r_nxt.mem_addr = ea_adjust(mode_r, req.a);
        r_nxt.result   = r_nxt.mem_addr;
      end
      cmv_pkg::CMV_OP_FETCH:
      begin
        r_nxt.mem_addr = prog_adjust(mode_r, {req.a[31:1], 1'b0});
        r_nxt.mem_wide = fetch_wide;
        pc_nxt = prog_adjust(mode_r, r_nxt.mem_addr +
                             (fetch_wide ? cmv_pkg::PUSH_WORD : cmv_pkg::PUSH_HALF));
        r_nxt.result = pc_nxt;
      end
      cmv_pkg::CMV_OP_EXC:
      begin
        r_nxt.table_addr = wide_mode ? {22'h0, req.a[7:0], 2'b00} :
                                       {23'h0, req.a[7:0], 1'b0};
        r_nxt.result   = prog_adjust(mode_r, req.b);
        sp_nxt         = sp_r - frame_sz;
        r_nxt.mem_addr = sp_nxt;
        r_nxt.mem_data = (wide_mode && !max_mode) ? {ccr_r, pc_img[23:0]} : pc_img;
        r_nxt.mem_aux  = max_mode ? {16'h0000, exr_r, ccr_r} :
                         (wide_mode ? 32'h0 : {24'h0, ccr_r});
        r_nxt.mem_wide  = wide_mode;
        r_nxt.mem_write = 1'b1;
        ccr_nxt[cmv_pkg::CCR_I_BIT] = 1'b1;
        pc_nxt = r_nxt.result;
      end
      cmv_pkg::CMV_OP_IND_JUMP,
      cmv_pkg::CMV_OP_IND_CALL:
      begin
        r_nxt.table_addr = {24'h0, req.a[7:0]};
        r_nxt.result     = prog_adjust(mode_r, req.b);
        pc_nxt           = r_nxt.result;
        r_nxt.mem_wide   = wide_mode;
        if (req.op == cmv_pkg::CMV_OP_IND_CALL)
        begin
          sp_nxt          = sp_r - push_sz;
          r_nxt.mem_addr  = sp_nxt;
          r_nxt.mem_data  = pc_img;
          r_nxt.mem_write = 1'b1;
        end
      end
      cmv_pkg::CMV_OP_CALL:
      begin
        r_nxt.result    = prog_adjust(mode_r, req.b);
        pc_nxt          = r_nxt.result;
        sp_nxt          = sp_r - push_sz;
        r_nxt.mem_addr  = sp_nxt;
        r_nxt.mem_data  = pc_img;
        r_nxt.mem_wide  = wide_mode;
        r_nxt.mem_write = 1'b1;
      end
      cmv_pkg::CMV_OP_RET:
      begin
        r_nxt.mem_addr = sp_r;
        r_nxt.mem_wide = wide_mode;
        sp_nxt         = sp_r + push_sz;
        r_nxt.result   = prog_adjust(mode_r, req.b);
        pc_nxt         = r_nxt.result;
      end
      cmv_pkg::CMV_OP_RTE:
      begin
        r_nxt.mem_addr = sp_r;
        r_nxt.mem_wide = wide_mode;
        sp_nxt         = sp_r + frame_sz;
        r_nxt.result   = prog_adjust(mode_r, req.b);
        pc_nxt         = r_nxt.result;
        ccr_nxt        = (wide_mode && !max_mode) ? req.b[31:24] : req.a[7:0];
        exr_nxt        = max_mode ? req.a[15:8] : exr_r;
      end
      cmv_pkg::CMV_OP_STEP:
      begin
        r_nxt.result   = req.a + req.b;
        r_nxt.mem_addr = ea_adjust(mode_r, r_nxt.result);
      end
      cmv_pkg::CMV_OP_ARITH:
      begin
        r_nxt.result = arith(req.kind, req.a, req.b);
        lat_nxt      = states_of(req.kind);
      end
      cmv_pkg::CMV_OP_SLEEP:
      begin
        sleep_nxt = 1'b1;
      end
      default:
      begin
        r_nxt.result = 32'h0;
      end
    endcase
  end

  // Architectural state; a register write lands a cycle after its handshake and holds operations off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r  <= cmv_pkg::CTRL_RST;
      sp_r    <= cmv_pkg::SP_RST;
      pc_r    <= cmv_pkg::PC_RST;
      ccr_r   <= cmv_pkg::CCR_RST;
      exr_r   <= cmv_pkg::EXR_RST;
      sleep_r <= 1'b0;
    end
    else
    begin
      if (accept)
      begin
        sp_r  <= sp_nxt;
        pc_r  <= pc_nxt;
        ccr_r <= ccr_nxt;
        exr_r <= exr_nxt;
      end
      else if (wr_sp)
      begin
        sp_r <= merge(sp_r, wdata_r, wstrb_r);
      end
      else if (wr_pc)
      begin
        pc_r <= merge(pc_r, wdata_r, wstrb_r);
      end
      else if (wr_flags)
      begin
        {exr_r, ccr_r} <= flags_mrg[15:0];
      end
      if (wr_ctrl)
      begin
        ctrl_r <= {31'h0, ctrl_mrg[cmv_pkg::CTRL_FETCH_BIT]};
      end
      if (accept && sleep_nxt)
      begin
        sleep_r <= 1'b1;
      end
      else if (wake)
      begin
        sleep_r <= 1'b0;
      end
    end
  end

  // Answer timing: result stands from acceptance, valid pulses after the state count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r     <= cmv_pkg::CMV_IDLE;
      cnt_r       <= 5'h00;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end
    else
    begin
      rsp_valid_r <= 1'b0;
      unique case (state_r)
        cmv_pkg::CMV_IDLE:
        begin
          if (accept)
          begin
            rsp_r <= r_nxt;
            if (lat_nxt == cmv_pkg::ST_ONE)
            begin
              rsp_valid_r <= 1'b1;
            end
            else
            begin
              cnt_r   <= lat_nxt - cmv_pkg::ST_ONE;
              state_r <= cmv_pkg::CMV_BUSY;
            end
          end
        end
        cmv_pkg::CMV_BUSY:
        begin
          cnt_r <= cnt_r - 5'h01;
          if (cnt_r == 5'h01)
          begin
            rsp_valid_r <= 1'b1;
            state_r     <= cmv_pkg::CMV_IDLE;
          end
        end
      endcase
    end
  end

  assign rsp_valid          = rsp_valid_r;
  assign rsp                = rsp_r;
  assign fetch_width_select = fetch_wide;
  assign sleeping           = sleep_r;
  assign mode               = mode_r;

endmodule : cmv_core

// [dv/cmv_mem_model.sv]
module cmv_mem_model (
  input  wire logic [31:0] addr,
  output logic      [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Reserved top byte is zero only in the indirect-operand region
  assign rdata = {addr[9] ? 8'h00 : 8'hff, 16'habcd, addr[7:0]};
endmodule : cmv_mem_model

// [dv/cmv_core_props.sv]
module cmv_core_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire cmv_pkg::cmv_req_t  req,
  input wire logic               rsp_valid,
  input wire cmv_pkg::cmv_rsp_t  rsp,
  input wire logic               sleeping,
  input wire cmv_pkg::cmv_mode_t mode
);
  wire logic        acc      = req_valid && req_ready;
  wire logic        ea_go    = acc && req.op == cmv_pkg::CMV_OP_EA;
  wire logic        exc_go   = acc && req.op == cmv_pkg::CMV_OP_EXC;
  wire logic        fet_go   = acc && req.op == cmv_pkg::CMV_OP_FETCH;
  wire logic        ind_go   = acc && req.op == cmv_pkg::CMV_OP_IND_JUMP;
  wire logic        sleep_go = acc && req.op == cmv_pkg::CMV_OP_SLEEP;
  wire logic        is_arith = acc && req.op == cmv_pkg::CMV_OP_ARITH;
  wire logic [31:0] ea_n     = {16'h0000, req.a[15:0]};
  wire logic [23:0] ea_m     = {{8{req.a[15]}}, req.a[15:0]};
  wire logic [31:0] t24      = {8'h00, req.b[23:0]};
  wire logic [31:0] tb32     = req.b;
  wire logic [31:0] ind8     = {24'h000000, req.a[7:0]};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ea_norm_a: assert property (ea_go && mode == cmv_pkg::CMV_NORMAL
    |=> rsp.mem_addr == $past(ea_n)) else $error("normal address wrong");
  ea_mid_a: assert property (ea_go && mode == cmv_pkg::CMV_MIDDLE
    |=> rsp.mem_addr[23:0] == $past(ea_m)) else $error("middle address wrong");
  exc_adv_a: assert property (exc_go && mode == cmv_pkg::CMV_ADVANCED
    |=> rsp.result == $past(t24)) else $error("vector target wrong");
  exc_max_a: assert property (exc_go && mode == cmv_pkg::CMV_MAXIMUM
    |=> rsp.result == $past(tb32)) else $error("full vector target wrong");
  ind_tab_a: assert property (ind_go
    |=> rsp.table_addr == $past(ind8)) else $error("indirect location wrong");
  fetch_lsb_a: assert property (fet_go |=> !rsp.mem_addr[0])
    else $error("fetch address odd");
  sleep_only_a: assert property ($rose(sleeping) |-> $past(sleep_go))
    else $error("sleep without sleep op");
  mode_hold_a: assert property ($past(aresetn) |=> $stable(mode))
    else $error("mode changed in run");
  mul32_lat_a: assert property (is_arith && req.kind == cmv_pkg::CMV_MUL32
    |=> !rsp_valid [*4] ##1 rsp_valid) else $error("wide multiply latency");
  div16_lat_a: assert property (is_arith && req.kind == cmv_pkg::CMV_DIV16_8
    |-> ##10 rsp_valid) else $error("short divide latency");
  div32_lat_a: assert property (is_arith && req.kind inside {cmv_pkg::CMV_DIV32_16,
    cmv_pkg::CMV_DIV32_32} |-> ##18 rsp_valid) else $error("long divide latency");
  cover property (sleep_go);
  cover property (exc_go && mode == cmv_pkg::CMV_MAXIMUM);
  cover property (is_arith && req.kind == cmv_pkg::CMV_DIV32_32);
endmodule : cmv_core_props

bind cmv_core cmv_core_props u_props (.aclk, .aresetn, .req_valid, .req_ready, .req,
  .rsp_valid, .rsp, .sleeping, .mode);

// [dv/cmv_core_tb.sv]
`define CHK(n, e, g) tests_run++; if ((g) !== (e)) begin $display("MISMATCH %s exp %h got %h", n, e, g); n_errors++; end
module cmv_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] EA_X [4] = '{32'h0000_8642, 32'h00ff_8642, 32'h1234_8642, 32'h1234_8642};
  localparam logic [31:0] EXC_X [4] = '{32'h0000_cd06, 32'h00ab_cd0c, 32'h00ab_cd0c, 32'hffab_cd0c};
  localparam int          LAT_X [8] = '{1, 1, 1, 1, 5, 10, 18, 18};
  logic               aclk = 1'b0, aresetn = 1'b0, wake = 1'b0, req_valid = 1'b0;
  logic [1:0]         mode_strap = 2'h2;
  cmv_pkg::cmv_req_t  req = '0;
  logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]        s_axi_wdata = 32'h0000_0000, s_axi_rdata, mem_a = 32'h0000_0000, mem_d;
  logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire logic [3:0]    s_axi_wstrb = 4'hf;
  logic               req_ready, rsp_valid, fetch_width_select, sleeping, s_axi_awready;
  logic               s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  cmv_pkg::cmv_rsp_t  rsp;
  cmv_pkg::cmv_mode_t mode;
  int                 n_errors = 0, tests_run = 0;
  cmv_core u_dut (.aclk, .aresetn, .mode_strap, .wake, .req_valid, .req_ready, .req, .rsp_valid,
    .rsp, .fetch_width_select, .sleeping, .mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  cmv_mem_model u_mem (.addr(mem_a), .rdata(mem_d));
  always #2.5 aclk = ~aclk;
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic rst(input logic [1:0] m);
    mode_strap <= m;
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    `CHK("bresp", cmv_pkg::AXI_OKAY, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic op(input cmv_pkg::cmv_op_t o, input cmv_pkg::cmv_kind_t k,
                    input logic [31:0] a, input logic [31:0] b, output int lat);
    @(posedge aclk);
    req <= '{o, k, a, b};
    req_valid <= 1'b1;
    do @(posedge aclk); while (!req_ready);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge aclk);
      lat++;
    end
    while (!rsp_valid && lat < 40);
  endtask : op
  task automatic mem(input logic [31:0] a, output logic [31:0] d);
    mem_a = a;
    #1;
    d = mem_d;
  endtask : mem
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    int          lat;
    rd(cmv_pkg::REG_STATUS, d, r);
    `CHK("status", 32'h0000_0012, d)
    wr(cmv_pkg::REG_CTRL, 32'h0000_0001);
    `CHK("fetch_sel", 1'b1, fetch_width_select)
    op(cmv_pkg::CMV_OP_FETCH, cmv_pkg::CMV_ADD, 32'h0000_2001, 32'h0, lat);
    `CHK("fetch_addr", 32'h0000_2000, rsp.mem_addr)
    `CHK("fetch_wide", 1'b1, rsp.mem_wide)
    op(cmv_pkg::CMV_OP_EA, cmv_pkg::CMV_ADD, 32'h1234_8642, 32'h0, lat);
    `CHK("data_addr", 32'h1234_8642, rsp.mem_addr)
    wr(cmv_pkg::REG_CTRL, 32'h0000_0000);
    `CHK("fetch_sel_off", 1'b0, fetch_width_select)
    rd(8'h20, d, r);
    `CHK("unmapped_resp", cmv_pkg::AXI_SLVERR, r)
    `CHK("unmapped_data", 32'h0000_0000, d)
  endtask : t_regs
  task automatic t_arith;
    int lat;
    for (int k = 0; k < 8; k++)
    begin
      op(cmv_pkg::CMV_OP_ARITH, cmv_pkg::cmv_kind_t'(k), 32'h0001_0003, 32'h0000_0002, lat);
      `CHK("latency", LAT_X[k], lat)
    end
  endtask : t_arith
  task automatic t_sleep;
    int lat;
    op(cmv_pkg::CMV_OP_SLEEP, cmv_pkg::CMV_ADD, 32'h0, 32'h0, lat);
    `CHK("sleeping", 1'b1, sleeping)
    `CHK("ready_asleep", 1'b0, req_ready)
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    @(posedge aclk);
    `CHK("awake", 1'b0, sleeping)
  endtask : t_sleep
  task automatic t_modes;
    logic [31:0] d, v, sp;
    logic [1:0]  r;
    int          lat;
    for (int m = 0; m < 4; m++)
    begin
      rst(m[1:0]);
      `CHK("mode", m[1:0], mode)
      op(cmv_pkg::CMV_OP_EA, cmv_pkg::CMV_ADD, 32'h1234_8642, 32'h0, lat);
      `CHK("ea", EA_X[m], rsp.mem_addr)
      op(cmv_pkg::CMV_OP_STEP, cmv_pkg::CMV_ADD, 32'h0000_ffff, 32'h1, lat);
      `CHK("step_carry", 32'h0001_0000, rsp.result)
      wr(cmv_pkg::REG_FLAGS, 32'h0000_0000);
      wr(cmv_pkg::REG_SP, 32'h0000_0100);
      mem((m == 0) ? 32'h0000_0006 : 32'h0000_000c, v);
      op(cmv_pkg::CMV_OP_EXC, cmv_pkg::CMV_ADD, 32'h0000_0003, v, lat);
      `CHK("vec_addr", (m == 0) ? 32'h0000_0006 : 32'h0000_000c, rsp.table_addr)
      `CHK("vec_target", EXC_X[m], rsp.result)
      `CHK("exc_push", 1'b1, rsp.mem_write)
      rd(cmv_pkg::REG_FLAGS, d, r);
      `CHK("mask", 1'b1, d[cmv_pkg::CCR_I_BIT])
      sp = 32'h0000_0100 - ((m == 3) ? 32'h0000_0008 : 32'h0000_0004);
      rd(cmv_pkg::REG_SP, d, r);
      `CHK("exc_sp", sp, d)
      mem(32'h0000_0255, v);
      op(cmv_pkg::CMV_OP_IND_JUMP, cmv_pkg::CMV_ADD, 32'h0000_0055, v, lat);
      `CHK("ind", (m == 0) ? 32'h0000_cd55 : 32'h00ab_cd55, rsp.result)
      op(cmv_pkg::CMV_OP_CALL, cmv_pkg::CMV_ADD, 32'h0, 32'h0000_0400, lat);
      `CHK("call_pc", (m == 0) ? 32'h0000_cd55 : 32'h00ab_cd55, rsp.mem_data)
      rd(cmv_pkg::REG_SP, d, r);
      `CHK("call_sp", sp - ((m == 0) ? 32'h2 : 32'h4), d)
    end
  endtask : t_modes
  initial
  begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    rst(2'h2);
    t_regs();
    t_arith();
    t_sleep();
    t_modes();
    tally_and_finish();
  end
endmodule : cmv_core_tb
